/* verilog/jic_pkg.sv */
`default_nettype none
package jic_pkg;
	localparam int JIC_AXIS_W   = 8;
	localparam int JIC_CLK_HZ   = 125_000_000;
	localparam int JIC_IDLE_S   = 120;
	localparam longint JIC_IDLE_CYC = longint'(JIC_IDLE_S) * JIC_CLK_HZ;
	localparam int JIC_POLL_US  = 1000;
	localparam int JIC_POLL_CYC = JIC_POLL_US * (JIC_CLK_HZ / 1_000_000);
	localparam logic [6:0] JIC_THR_MIN = 7'h14;
	localparam logic [6:0] JIC_THR_MAX = 7'h50;
	localparam logic [6:0] JIC_THR_RST = 7'h32;
	localparam logic [2:0] JIC_FLASH_MODULE = 3'h1;
	localparam logic [3:0] JIC_A_CFG    = 4'h0;
	localparam logic [3:0] JIC_A_THR    = 4'h1;
	localparam logic [3:0] JIC_A_NEUT   = 4'h2;
	localparam logic [3:0] JIC_A_STAT   = 4'h3;
	localparam logic [3:0] JIC_A_IRQ    = 4'h4;
	localparam logic [3:0] JIC_A_IRQ_EN = 4'h5;
	localparam logic [3:0] JIC_A_IRQ_CL = 4'h6;
	localparam logic [31:0] JIC_CFG_RST = 32'h0000_0027;
	localparam int JIC_CFG_BITS = 10;
	localparam int JIC_IRQ_BITS = 3;
	localparam logic [7:0] JIC_NEUT_RST = 8'h0c;

	typedef enum logic [1:0] {
		JIC_SRC_MAIN,
		JIC_SRC_ATTEND,
		JIC_SRC_REMOTE
	} jic_src_t;

	typedef struct packed {
		logic signed [JIC_AXIS_W-1:0] fwd;
		logic signed [JIC_AXIS_W-1:0] turn;
	} jic_stick_t;

	typedef struct packed {
		logic remote_module_lr_swap;
		logic rotate_main_stick;
		logic main_lr_swap;
		logic fr_swap;
		logic attendant_unit_enable;
		logic attendant_lr_swap;
		logic attendant_pushbutton_mode;
		logic attendant_idle_timeout;
		logic remote_module_enable;
		logic remote_proportional_stick;
	} jic_cfg_t;
endpackage
`default_nettype wire

/* verilog/jic_swch.sv */
`timescale 1ns/1ps
`default_nettype none
module jic_swch #(
	parameter int W = 8
) (
	input  wire logic                clk,   // system clock
	input  wire logic                sys_rst, // async reset
	input  wire logic                smp,   // sample strobe
	input  wire logic signed [W-1:0] val,   // axis value
	input  wire logic        [W-1:0] lim,   // threshold in counts
	output logic                     on     // switch state
);
	logic [W-1:0] mag;
	assign mag = val[W-1] ? W'(-val) : val;
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			on <= 1'b0;
		else if (smp)
			on <= mag > lim;
	end
endmodule
`default_nettype wire

/* verilog/jic_core.sv */
// Notes on behaviour
// - rotate set: fwd->right, right->rev, rev->left, left->fwd on main stick.
// - rotate plus both swaps gives the opposite rotation, fwd->left.
// - attendant enable lets an attendant unit take over driving.
// - attendant enable set: poll for the unit regularly, even if absent.
// - attendant lr swap inverts only the attendant unit turn axis.
// - remote lr swap inverts only the remote module turn axis.
// - takeover switch is a push button in pushbutton mode, else a level.
// - pushbutton plus timeout: two idle minutes return to user mode.
// - pushbutton without timeout: stay attendant until pressed again.
// - level switch mode ignores the timeout setting.
// - remote enable: take remote demands when profile selects remote.
// - remote source with module absent raises module fault, flash code 1.
// - switched remote stick: small speed and turn demands forced to zero.
// - the zero band is sized by the neutral maximum value.
// - joystick switch on beyond threshold, 20 to 80 percent, default 50.
`timescale 1ns/1ps
`default_nettype none
module jic_core
	import jic_pkg::*;
#(
	parameter longint IDLE_CYC = jic_pkg::JIC_IDLE_CYC,
	parameter int     POLL_CYC = jic_pkg::JIC_POLL_CYC
) (
	input  wire logic              clk,          // 125 MHz clock
	input  wire logic              sys_rst,      // async reset, high
	input  wire logic [3:0]        reg_addr,     // register word address
	input  wire logic [31:0]       reg_wdata,    // write data
	input  wire logic              reg_wr,       // write strobe
	input  wire logic              reg_rd,       // read strobe
	output logic      [31:0]       reg_rdata,    // read data, next cycle
	input  wire jic_pkg::jic_stick_t main_stick, // main unit deflection
	input  wire jic_pkg::jic_stick_t attend_stick, // attendant deflection
	input  wire jic_pkg::jic_stick_t remote_stick, // remote deflection
	input  wire logic              stick_valid,  // new sample strobe
	input  wire logic              attend_present, // attendant unit seen
	input  wire logic              remote_present, // remote module seen
	input  wire logic              takeover_sw,  // attendant switch level
	input  wire logic              remote_src_sel, // profile wants remote
	output logic                   attend_poll,  // presence poll pulse
	output jic_pkg::jic_stick_t    demand,       // conditioned demand
	output logic                   attend_mode,  // attendant drives
	output logic                   module_fault, // fault flag
	output logic      [2:0]        flash_code,   // fault flash code
	output logic                   sw_fwd_on,    // fwd axis switch on
	output logic                   sw_turn_on,   // turn axis switch on
	output logic                   irq           // interrupt level
);
	localparam int W = JIC_AXIS_W;
	localparam int IW = $clog2(IDLE_CYC + 1);
	localparam int PW = $clog2(POLL_CYC + 1);

	jic_cfg_t   cfg;
	logic [6:0] thr_pct;
	logic [W-1:0] neut_max;
	logic [JIC_IRQ_BITS-1:0] irq_stat, irq_en;
	logic [IW-1:0] idle_cnt;
	logic [PW-1:0] poll_cnt;
	logic sw_q, smp_d;

	function automatic jic_stick_t lr_flip(input jic_stick_t s,
		input logic en);
		jic_stick_t r;
		r = s;
		if (en)
			r.turn = W'(-s.turn);
		return r;
	endfunction

	// both swaps act on the raw deflection; rotating after them
	// turns the mapping the other way round
	jic_stick_t main_sw, main_fr, main_fin;
	assign main_sw  = lr_flip(main_stick, cfg.main_lr_swap);
	assign main_fr.fwd  = cfg.fr_swap ? W'(-main_sw.fwd)
		: main_sw.fwd;
	assign main_fr.turn = main_sw.turn;
	// rotation maps fwd deflection onto turn and right onto reverse
	assign main_fin.fwd  = cfg.rotate_main_stick ? W'(-main_fr.turn)
		: main_fr.fwd;
	assign main_fin.turn = cfg.rotate_main_stick ? main_fr.fwd
		: main_fr.turn;

	jic_stick_t att_c, rem_c, rem_z, sel;
	assign att_c = lr_flip(attend_stick, cfg.attendant_lr_swap);
	assign rem_c = lr_flip(remote_stick,
		cfg.remote_module_lr_swap);

	function automatic logic in_band(input logic signed [W-1:0] v,
		input logic [W-1:0] lim);
		logic [W-1:0] m;
		m = v[W-1] ? W'(-v) : v;
		return m <= lim;
	endfunction

	wire zero_ok = !cfg.remote_proportional_stick;
	assign rem_z.fwd  = (zero_ok && in_band(rem_c.fwd, neut_max)) ? '0
		: rem_c.fwd;
	assign rem_z.turn = (zero_ok && in_band(rem_c.turn, neut_max)) ? '0
		: rem_c.turn;

	wire use_remote = cfg.remote_module_enable && remote_src_sel
		&& remote_present;
	wire fault_now = cfg.remote_module_enable && remote_src_sel
		&& !remote_present;
	wire att_ok = cfg.attendant_unit_enable && attend_present;

	jic_src_t src;
	assign src = (attend_mode && att_ok) ? JIC_SRC_ATTEND
		: use_remote ? JIC_SRC_REMOTE : JIC_SRC_MAIN;
	always_comb begin
		case (src)
			JIC_SRC_ATTEND: sel = att_c;
			JIC_SRC_REMOTE: sel = rem_z;
			default:        sel = main_fin;
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			demand <= '0;
		else if (stick_valid)
			demand <= fault_now ? '0 : sel;
	end

	// poll runs whether or not a unit answers
	wire poll_hit = poll_cnt == PW'(POLL_CYC - 1);
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			poll_cnt <= '0;
		else if (!cfg.attendant_unit_enable || poll_hit)
			poll_cnt <= '0;
		else
			poll_cnt <= poll_cnt + 1'b1;
	end
	assign attend_poll = cfg.attendant_unit_enable && poll_hit;

	// attendant mode
	wire press = takeover_sw && !sw_q;
	wire att_act = stick_valid && src == JIC_SRC_ATTEND
		&& (attend_stick.fwd != '0 || attend_stick.turn != '0);
	wire use_to = cfg.attendant_pushbutton_mode
		&& cfg.attendant_idle_timeout;
	wire idle_exp = use_to && idle_cnt == IW'(IDLE_CYC - 1);
	logic next_mode;
	always_comb begin
		next_mode = attend_mode;
		if (!att_ok)
			next_mode = 1'b0;
		else if (!cfg.attendant_pushbutton_mode)
			next_mode = takeover_sw;
		else if (press)
			next_mode = !attend_mode;
		else if (attend_mode && idle_exp)
			next_mode = 1'b0;
	end
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			attend_mode <= 1'b0;
			sw_q        <= 1'b0;
		end else begin
			attend_mode <= next_mode;
			sw_q        <= takeover_sw;
		end
	end
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			idle_cnt <= '0;
		else if (!attend_mode || att_act || press || idle_exp)
			idle_cnt <= '0;
		else if (use_to)
			idle_cnt <= idle_cnt + 1'b1;
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			module_fault <= 1'b0;
			flash_code   <= '0;
		end else begin
			module_fault <= fault_now;
			flash_code   <= fault_now ? JIC_FLASH_MODULE : '0;
		end
	end

	// threshold in counts: full scale times percent over 100
	localparam int FS = (1 << (W - 1)) - 1;
	logic [W-1:0] thr_cnt;
	assign thr_cnt = W'((FS * 32'(thr_pct)) / 100);
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			smp_d <= 1'b0;
		else
			smp_d <= stick_valid;
	end
	jic_swch #(.W(W)) u_sw_fwd (
		.clk    (clk),
		.sys_rst(sys_rst),
		.smp    (smp_d),
		.val    (demand.fwd),
		.lim    (thr_cnt),
		.on     (sw_fwd_on)
	);
	jic_swch #(.W(W)) u_sw_turn (
		.clk    (clk),
		.sys_rst(sys_rst),
		.smp    (smp_d),
		.val    (demand.turn),
		.lim    (thr_cnt),
		.on     (sw_turn_on)
	);

	// interrupts: set wins over clear
	logic [JIC_IRQ_BITS-1:0] ev;
	logic fault_q;
	assign ev = {fault_now && !module_fault,
		attend_mode && !next_mode, !attend_mode && next_mode};
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			irq_stat <= '0;
		else if (reg_wr && reg_addr == JIC_A_IRQ_CL)
			irq_stat <= (irq_stat & ~reg_wdata[JIC_IRQ_BITS-1:0]) | ev;
		else
			irq_stat <= irq_stat | ev;
	end
	assign irq = |(irq_stat & irq_en);
	assign fault_q = module_fault;

	// registers; out of range thresholds are clamped on write
	wire [6:0] wthr = reg_wdata[6:0];
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cfg      <= jic_cfg_t'(JIC_CFG_RST[JIC_CFG_BITS-1:0]);
			thr_pct  <= JIC_THR_RST;
			neut_max <= JIC_NEUT_RST;
			irq_en   <= '0;
		end else if (reg_wr) begin
			if (reg_addr == JIC_A_CFG)
				cfg <= jic_cfg_t'(reg_wdata[JIC_CFG_BITS-1:0]);
			else if (reg_addr == JIC_A_THR)
				thr_pct <= (wthr < JIC_THR_MIN) ? JIC_THR_MIN
					: (wthr > JIC_THR_MAX) ? JIC_THR_MAX : wthr;
			else if (reg_addr == JIC_A_NEUT)
				neut_max <= reg_wdata[W-1:0];
			else if (reg_addr == JIC_A_IRQ_EN)
				irq_en <= reg_wdata[JIC_IRQ_BITS-1:0];
		end
	end

	logic [31:0] rmux;
	assign rmux = (reg_addr == JIC_A_CFG) ? 32'(cfg)
		: (reg_addr == JIC_A_THR) ? 32'(thr_pct)
		: (reg_addr == JIC_A_NEUT) ? 32'(neut_max)
		: (reg_addr == JIC_A_STAT) ? 32'({flash_code, fault_q,
			sw_turn_on, sw_fwd_on, src, attend_mode})
		: (reg_addr == JIC_A_IRQ) ? 32'(irq_stat)
		: (reg_addr == JIC_A_IRQ_EN) ? 32'(irq_en)
		: 32'h0000_0000;
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			reg_rdata <= '0;
		else
			reg_rdata <= reg_rd ? rmux : 32'h0000_0000;
	end

	sequence s_main_rotated;
		stick_valid && cfg.rotate_main_stick && !cfg.main_lr_swap
		&& !cfg.fr_swap && src == JIC_SRC_MAIN && !fault_now;
	endsequence
	sequence s_pb_press;
		att_ok && cfg.attendant_pushbutton_mode && press;
	endsequence

	a_rotate_map: assert property (
		@(posedge clk) disable iff (sys_rst)
		s_main_rotated |=> demand.turn == $past(main_stick.fwd))
		else $error("rotated forward did not become right");
	a_fault_code: assert property (
		@(posedge clk) disable iff (sys_rst)
		fault_now |=> module_fault && flash_code == JIC_FLASH_MODULE)
		else $error("module fault code wrong");
	a_poll_gap: assert property (
		@(posedge clk) disable iff (sys_rst)
		attend_poll |=> !attend_poll)
		else $error("poll pulse too long");
	a_level_mode: assert property (
		@(posedge clk) disable iff (sys_rst)
		att_ok && !cfg.attendant_pushbutton_mode
		|=> attend_mode == $past(takeover_sw))
		else $error("level switch not followed");
	a_push_toggle: assert property (
		@(posedge clk) disable iff (sys_rst)
		s_pb_press |=> attend_mode != $past(attend_mode))
		else $error("press did not toggle the mode");
	a_idle_exit: assert property (
		@(posedge clk) disable iff (sys_rst)
		attend_mode && idle_exp && !press && att_ok |=> !attend_mode)
		else $error("idle timeout missed");
	a_no_timeout: assert property (
		@(posedge clk) disable iff (sys_rst)
		attend_mode && att_ok && cfg.attendant_pushbutton_mode
		&& !cfg.attendant_idle_timeout && !press |=> attend_mode)
		else $error("left attendant without press");
	a_level_noto: assert property (
		@(posedge clk) disable iff (sys_rst)
		!cfg.attendant_pushbutton_mode && att_ok && attend_mode
		&& takeover_sw |=> attend_mode)
		else $error("timeout used with level switch");
	a_dead_zone: assert property (
		@(posedge clk) disable iff (sys_rst)
		stick_valid && src == JIC_SRC_REMOTE && zero_ok && !fault_now
		&& in_band(rem_c.fwd, neut_max) |=> demand.fwd == '0)
		else $error("small remote speed passed");
	a_thr_range: assert property (
		@(posedge clk) disable iff (sys_rst)
		thr_pct >= JIC_THR_MIN && thr_pct <= JIC_THR_MAX)
		else $error("threshold out of range");
endmodule
`default_nettype wire

/* verif/jic_far.sv */
`timescale 1ns/1ps
`default_nettype none
module jic_far (
	input  wire logic             clk,            // bench clock
	input  wire logic             attend_poll,    // poll from block
	output var jic_pkg::jic_stick_t main_stick,   // main deflection
	output var jic_pkg::jic_stick_t attend_stick, // attendant deflection
	output var jic_pkg::jic_stick_t remote_stick, // remote deflection
	output var logic              stick_valid,    // sample strobe
	output var logic              attend_present, // attendant fitted
	output var logic              remote_present, // remote fitted
	output var logic              takeover_sw     // attendant switch
);
	import jic_pkg::*;
	jic_stick_t a;
	jic_stick_t r;
	int         poll_cnt = 0;
	// an absent module holds nothing: show the inverse, not a stale value
	assign attend_stick = attend_present ? a : ~a;
	assign remote_stick = remote_present ? r : ~r;
	initial begin
		main_stick = '0;
		a = '0;
		r = '0;
		stick_valid = 1'b0;
		attend_present = 1'b1;
		remote_present = 1'b1;
		takeover_sw = 1'b0;
	end
	always @(posedge clk) if (attend_poll) poll_cnt <= poll_cnt + 1;
	task automatic send(input jic_stick_t m, sa, sr);
		@(posedge clk);
		main_stick <= m;
		a <= sa;
		r <= sr;
		stick_valid <= 1'b1;
		@(posedge clk);
		stick_valid <= 1'b0;
	endtask
	task automatic set(input logic pa, pr, sw);
		@(posedge clk);
		attend_present <= pa;
		remote_present <= pr;
		takeover_sw <= sw;
	endtask
endmodule
`default_nettype wire

/* verif/jic_core_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module jic_core_bench;
	import jic_pkg::*;
	logic        clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic [3:0]  reg_addr = '0;
	logic [31:0] reg_wdata = '0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic        remote_src_sel = 1'b0;
	logic [31:0] reg_rdata;
	jic_stick_t  main_stick, attend_stick, remote_stick, demand, d, e;
	logic        stick_valid, attend_present, remote_present, takeover_sw;
	logic        attend_poll, attend_mode, module_fault, irq;
	logic        sw_fwd_on, sw_turn_on;
	logic [2:0]  flash_code;
	int          bad_count = 0;
	int          total_checks = 0;
	int          cyc = 0;
	int          p0;
	logic [31:0] cf[3] = '{32'h0, 32'h100, 32'h1c0};
	jic_stick_t  dir[4] = '{16'h2800, 16'h0028, 16'hd800, 16'h00d8};
	always #4 clk = ~clk;
	jic_core #(.IDLE_CYC(200), .POLL_CYC(16)) uut (
		.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .main_stick, .attend_stick, .remote_stick,
		.stick_valid, .attend_present, .remote_present, .takeover_sw,
		.remote_src_sel, .attend_poll, .demand, .attend_mode,
		.module_fault, .flash_code, .sw_fwd_on, .sw_turn_on, .irq
	);
	jic_far far (
		.clk, .attend_poll, .main_stick, .attend_stick, .remote_stick,
		.stick_valid, .attend_present, .remote_present, .takeover_sw
	);
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task automatic cy(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] x);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, x);
	endtask
	// demand lands one edge after the strobe, switches one edge later
	task automatic sm(input jic_stick_t m, sa, sr);
		far.send(m, sa, sr);
		cy(2);
	endtask
	task automatic press;
		far.set(1'b1, 1'b1, 1'b1);
		far.set(1'b1, 1'b1, 1'b0);
		cy(4);
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			bad_count++;
			print_verdict;
		end
	end
	initial begin
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		rd(JIC_A_CFG, 32'h027);
		rd(JIC_A_THR, 32'h32);
		rd(JIC_A_NEUT, 32'h0c);
		wr(4'h7, 32'hff);
		rd(4'h7, 32'h0);
		foreach (cf[i]) begin
			wr(JIC_A_CFG, cf[i]);
			for (int k = 0; k < 4; k++) begin
				d = dir[k];
				sm(d, 16'h0, 16'h0);
				e = (i == 0) ? d : (i == 1) ? {-d.turn, d.fwd} : {d.turn, -d.fwd};
				chk(32'(demand), 32'(e));
			end
		end
		p0 = far.poll_cnt;
		cy(64);
		chk(far.poll_cnt - p0, 0);
		wr(JIC_A_CFG, 32'h030);
		p0 = far.poll_cnt;
		cy(64);
		chk(far.poll_cnt - p0, 4);
		far.set(1'b1, 1'b1, 1'b1);
		cy(4);
		chk(attend_mode, 1);
		sm(16'h3030, 16'h141e, 16'h0);
		chk(32'(demand), 32'h14e2);
		wr(JIC_A_CFG, 32'h0b0);
		sm(16'h3030, 16'h141e, 16'h0);
		chk(32'(demand), 32'h14e2);
		wr(JIC_A_CFG, 32'h010);
		cy(4);
		chk(attend_mode, 0);
		sm(16'h141e, 16'h3030, 16'h0);
		chk(32'(demand), 32'h141e);
		far.set(1'b1, 1'b1, 1'b0);
		wr(JIC_A_CFG, 32'h013);
		remote_src_sel <= 1'b1;
		sm(16'h3030, 16'h3030, 16'h141e);
		chk(32'(demand), 32'h141e);
		wr(JIC_A_CFG, 32'h203);
		sm(16'h141e, 16'h3030, 16'h141e);
		chk(32'(demand), 32'h14e2);
		wr(JIC_A_NEUT, 32'h14);
		wr(JIC_A_CFG, 32'h003);
		sm(16'h3030, 16'h0, 16'h13ed);
		chk(32'(demand), 32'h13ed);
		wr(JIC_A_CFG, 32'h002);
		sm(16'h3030, 16'h0, 16'h13ed);
		chk(32'(demand), 32'h0);
		sm(16'h3030, 16'h0, 16'h1eed);
		chk(32'(demand), 32'h1e00);
		wr(JIC_A_IRQ_CL, 32'h7);
		wr(JIC_A_IRQ_EN, 32'h4);
		far.set(1'b1, 1'b0, 1'b0);
		sm(16'h3030, 16'h0, 16'h1e1e);
		chk({module_fault, flash_code}, 4'b1001);
		chk(32'(demand), 32'h0);
		chk(irq, 1);
		rd(JIC_A_IRQ, 32'h4);
		wr(JIC_A_IRQ_EN, 32'h0);
		cy(1);
		chk(irq, 0);
		far.set(1'b1, 1'b1, 1'b0);
		cy(2);
		chk(module_fault, 0);
		wr(JIC_A_IRQ_CL, 32'h4);
		rd(JIC_A_IRQ, 32'h0);
		remote_src_sel <= 1'b0;
		wr(JIC_A_CFG, 32'h02c);
		press;
		chk(attend_mode, 1);
		cy(150);
		chk(attend_mode, 1);
		cy(100);
		chk(attend_mode, 0);
		wr(JIC_A_CFG, 32'h028);
		press;
		cy(300);
		chk(attend_mode, 1);
		press;
		chk(attend_mode, 0);
		wr(JIC_A_CFG, 32'h024);
		far.set(1'b1, 1'b1, 1'b1);
		cy(300);
		chk(attend_mode, 1);
		far.set(1'b1, 1'b1, 1'b0);
		cy(4);
		chk(attend_mode, 0);
		wr(JIC_A_CFG, 32'h0);
		sm(16'h403f, 16'h0, 16'h0);
		chk({sw_fwd_on, sw_turn_on}, 2'b10);
		sm(16'hc1c0, 16'h0, 16'h0);
		chk({sw_fwd_on, sw_turn_on}, 2'b01);
		wr(JIC_A_THR, 32'h0a);
		rd(JIC_A_THR, 32'h14);
		sm(16'h1a19, 16'h0, 16'h0);
		chk({sw_fwd_on, sw_turn_on}, 2'b10);
		wr(JIC_A_THR, 32'h5a);
		rd(JIC_A_THR, 32'h50);
		sm(16'h6665, 16'h0, 16'h0);
		chk({sw_fwd_on, sw_turn_on}, 2'b10);
		print_verdict;
	end
endmodule
`default_nettype wire
